// ### design/bax_top.sv
// Purpose: Byte ALU slice for subtract, xor and nibble swap
// Assumes: Decode gives one-hot op with a one-cycle valid
// Notes:   Results appear one cycle after the request
// Function
// - Register minus accumulator, two's complement
// - Dest 0 to accumulator, 1 to register
// - Carry and digit carry from borrow
// - Literal xor into accumulator, zero only
// - Swap nibbles, keep flags, honour destination
// - Accumulator xor register, zero only
`include "bax_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bax_top (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  op_valid,
  input  wire logic [3:0]            op,
  input  wire logic [6:0]            reg_addr,
  input  wire logic                  dest_sel,
  input  wire bax_pkg::bax_byte_t    reg_val,
  input  wire bax_pkg::bax_byte_t    literal,
  output var bax_pkg::bax_byte_t     acc_out,
  output var bax_pkg::bax_byte_t     wb_data,
  output logic [6:0]                 wb_addr,
  output logic                       wb_en,
  output logic                       carry_flag,
  output logic                       digit_carry_flag,
  output logic                       zero_flag
);
  bax_pkg::bax_byte_t res;
  logic               c_new;
  logic               dc_new;
  logic               cdc_upd;
  logic               z_upd;

  bax_calc u_calc (
    .op               (op),
    .acc              (acc_out),
    .reg_val          (reg_val),
    .literal          (literal),
    .result           (res),
    .carry            (c_new),
    .digit_carry_flag (dc_new),
    .cdc_upd          (cdc_upd),
    .zero_upd         (z_upd)
  );

  // Where this request's result goes
  logic               to_acc;
  logic               to_reg;
  logic               cdc_take;
  logic               z_take;

  // Accumulator state
  bax_pkg::bax_byte_t acc_q;
  bax_pkg::bax_byte_t acc_d;

  // Writeback state
  bax_pkg::bax_byte_t wbd_q;
  bax_pkg::bax_byte_t wbd_d;
  logic [6:0]         wba_q;
  logic [6:0]         wba_d;
  logic               wbe_q;
  logic               wbe_d;

  // Status flag state
  logic               c_q;
  logic               c_d;
  logic               dc_q;
  logic               dc_d;
  logic               z_q;
  logic               z_d;

  // Literal xor always lands in the accumulator, whatever the select says
  function automatic logic dest_is_reg(input logic [3:0] o, input logic d);
    dest_is_reg = (d == `BAX_DEST_REG) && (o != bax_pkg::BAX_OP_XOR_LITERAL_INTO_ACC);
  endfunction : dest_is_reg

  // Zero test on an 8-bit result
  function automatic logic is_zero(input bax_pkg::bax_byte_t v);
    is_zero = (v == `BAX_ZERO_BYTE);
  endfunction : is_zero

  // Request decode, qualified by the strobe
  always_comb begin
    to_reg   = op_valid && dest_is_reg(op, dest_sel);
    to_acc   = op_valid && !dest_is_reg(op, dest_sel);
    cdc_take = op_valid && cdc_upd;
    z_take   = op_valid && z_upd;
  end

  // Accumulator loads the result on every request not bound for the register
  // A refused opcode still loads zero here, matching the datapath default
  always_comb begin
    acc_d = acc_q;
    if (to_acc) begin
      acc_d = res;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= `BAX_ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Writeback data holds between writes
  // Only the strobe marks a fresh value
  always_comb begin
    wbd_d = wbd_q;
    if (to_reg) begin
      wbd_d = res;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wbd_q <= `BAX_WB_RST;
    end else begin
      wbd_q <= wbd_d;
    end
  end

  // Writeback address follows the data
  // The full 0 to 127 range passes unchanged
  always_comb begin
    wba_d = wba_q;
    if (to_reg) begin
      wba_d = reg_addr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wba_q <= `BAX_WBA_RST;
    end else begin
      wba_q <= wba_d;
    end
  end

  // Writeback strobe pulses one cycle per register-bound result
  // It drops by default so one request cannot write twice
  always_comb begin
    wbe_d = 1'b0;
    if (to_reg) begin
      wbe_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wbe_q <= `BAX_STROBE_RST;
    end else begin
      wbe_q <= wbe_d;
    end
  end

  // Carry set means no borrow: accumulator not above register
  // Only the subtract touches it
  always_comb begin
    c_d = c_q;
    if (cdc_take) begin
      c_d = c_new;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_q <= `BAX_FLAG_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // Digit carry is the same test on the low nibbles
  // Swap and both xors leave it alone
  always_comb begin
    dc_d = dc_q;
    if (cdc_take) begin
      dc_d = dc_new;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_q <= `BAX_FLAG_RST;
    end else begin
      dc_q <= dc_d;
    end
  end

  // Zero follows the stored result on subtract and both xors
  // Swap leaves it alone
  always_comb begin
    z_d = z_q;
    if (z_take) begin
      z_d = is_zero(res);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      z_q <= `BAX_FLAG_RST;
    end else begin
      z_q <= z_d;
    end
  end

  // Every output comes straight from its register
  assign acc_out          = acc_q;
  assign wb_data          = wbd_q;
  assign wb_addr          = wba_q;
  assign wb_en            = wbe_q;
  assign carry_flag       = c_q;
  assign digit_carry_flag = dc_q;
  assign zero_flag        = z_q;
endmodule : bax_top
`default_nettype wire

// ### design/bax_consts.svh
// Purpose: Constants for the byte ALU slice
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef BAX_CONSTS_SVH
`define BAX_CONSTS_SVH
`define BAX_DATA_W      8
`define BAX_ADDR_W      7
`define BAX_ADDR_MAX    7'h7F
`define BAX_DEST_ACC    1'b0
`define BAX_DEST_REG    1'b1
`define BAX_ACC_RST     8'h00
`define BAX_ZERO_BYTE   8'h00
`define BAX_WB_RST      8'h00
`define BAX_WBA_RST     7'h00
`define BAX_STROBE_RST  1'b0
`define BAX_FLAG_RST    1'b0
`define BAX_LO_HI       3
`define BAX_HI_HI       7
`define BAX_HI_LO       4
`endif

// ### design/bax_pkg.sv
// Purpose: Types for the byte ALU slice
// Assumes: Nothing
// Notes:   Opcode select is one-hot
package bax_pkg;
  typedef enum logic [3:0] {
    BAX_OP_SUB_ACC_FROM_REG      = 4'h1,
    BAX_OP_XOR_LITERAL_INTO_ACC  = 4'h2,
    BAX_OP_NIBBLE_SWAP_REG       = 4'h4,
    BAX_OP_XOR_ACC_WITH_REG      = 4'h8
  } bax_op_e;
  typedef logic [7:0] bax_byte_t;
endpackage : bax_pkg

// ### design/bax_calc.sv
// Purpose: Combinational result and flag computation
// Assumes: Operands stable for the cycle
// Notes:   Flag enables tell which flags change
`include "bax_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bax_calc (
  input  wire logic [3:0]            op,
  input  wire bax_pkg::bax_byte_t    acc,
  input  wire bax_pkg::bax_byte_t    reg_val,
  input  wire bax_pkg::bax_byte_t    literal,
  output var bax_pkg::bax_byte_t     result,
  output logic                       carry,
  output logic                       digit_carry_flag,
  output logic                       cdc_upd,
  output logic                       zero_upd
);
  logic [8:0] diff;
  logic [4:0] ndiff;

  always_comb begin
    diff             = {1'b0, reg_val} - {1'b0, acc};
    ndiff            = {1'b0, reg_val[`BAX_LO_HI:0]} - {1'b0, acc[`BAX_LO_HI:0]};
    result           = 8'h00;
    cdc_upd          = 1'b0;
    zero_upd         = 1'b0;
    carry            = ~diff[8];
    digit_carry_flag = ~ndiff[4];
    unique case (op)
      bax_pkg::BAX_OP_SUB_ACC_FROM_REG: begin
        result   = diff[7:0];
        cdc_upd  = 1'b1;
        zero_upd = 1'b1;
      end
      bax_pkg::BAX_OP_XOR_LITERAL_INTO_ACC: begin
        result   = acc ^ literal;
        zero_upd = 1'b1;
      end
      bax_pkg::BAX_OP_NIBBLE_SWAP_REG: begin
        result = {reg_val[`BAX_LO_HI:0], reg_val[`BAX_HI_HI:`BAX_HI_LO]};
      end
      bax_pkg::BAX_OP_XOR_ACC_WITH_REG: begin
        result   = acc ^ reg_val;
        zero_upd = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end
endmodule : bax_calc
`default_nettype wire

// ### sim/bax_top_monitor.sv
// Purpose: Port assertions for bax_top
// Assumes: One clock, async reset
// Notes:   Bound after endmodule
`timescale 1ns/1ps
`default_nettype none
module bax_top_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       op_valid,
  input wire logic [3:0] op,
  input wire logic [6:0] reg_addr,
  input wire logic       dest_sel,
  input wire logic [7:0] reg_val,
  input wire logic [7:0] literal,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] wb_data,
  input wire logic [6:0] wb_addr,
  input wire logic       wb_en,
  input wire logic       carry_flag,
  input wire logic       digit_carry_flag,
  input wire logic       zero_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] pa, pr, pl;
  logic       pd;
  wire logic [2:0] f = {carry_flag, digit_carry_flag, zero_flag};
  wire logic s = op_valid && op == 4'h1, x = op_valid && op == 4'h2;
  wire logic w = op_valid && op == 4'h4, r = op_valid && op == 4'h8;
  always_ff @(posedge clk) {pa, pr, pl, pd} <= {acc_out, reg_val, literal, dest_sel};
  property p_sub; s && !dest_sel |=> acc_out == pr - pa; endproperty
  a_sub: assert property (p_sub) else $error("sub");
  property p_dst; (s || w || r) && dest_sel |=> wb_en && acc_out == pa; endproperty
  a_dst: assert property (p_dst) else $error("dst");
  property p_brw; s |=> f[2:1] == {pa <= pr, pa[3:0] <= pr[3:0]}; endproperty
  a_brw: assert property (p_brw) else $error("brw");
  property p_xl; x |=> acc_out == (pa ^ pl) && !wb_en && $stable(f[2:1]); endproperty
  a_xl: assert property (p_xl) else $error("xl");
  property p_swp; w |=> $stable(f) && (pd ? wb_data : acc_out) == {pr[3:0], pr[7:4]}; endproperty
  a_swp: assert property (p_swp) else $error("swp");
  property p_xr; r |=> (pd ? wb_data : acc_out) == (pa ^ pr) && $stable(f[2:1]); endproperty
  a_xr: assert property (p_xr) else $error("xr");
  property p_z; s || x || r |=> zero_flag == ((pd && !$past(x) ? wb_data : acc_out) == 8'h00);
  endproperty
  a_z: assert property (p_z) else $error("z");
  property p_wba; (s || w || r) && dest_sel |=> wb_addr == $past(reg_addr); endproperty
  a_wba: assert property (p_wba) else $error("wba");
  property p_idl; !op_valid |=> !wb_en && $stable(acc_out) && $stable(f); endproperty
  a_idl: assert property (p_idl) else $error("idl");
  cover property (x);
  cover property (s && dest_sel);
  cover property (w);
  cover property (r && !dest_sel);
endmodule : bax_top_monitor
bind bax_top bax_top_monitor u_mon (
  .clk              (clk),
  .sys_rst          (sys_rst),
  .op_valid         (op_valid),
  .op               (op),
  .reg_addr         (reg_addr),
  .dest_sel         (dest_sel),
  .reg_val          (reg_val),
  .literal          (literal),
  .acc_out          (acc_out),
  .wb_data          (wb_data),
  .wb_addr          (wb_addr),
  .wb_en            (wb_en),
  .carry_flag       (carry_flag),
  .digit_carry_flag (digit_carry_flag),
  .zero_flag        (zero_flag)
);
`default_nettype wire

// ### sim/byte_alu_sub_xor_swap_tb.sv
// Purpose: Directed bench for bax_top
// Assumes: Answer one cycle after request
// Notes:   Expected values worked by hand
`timescale 1ns/1ps
`default_nettype none
module byte_alu_sub_xor_swap_tb;
  logic       clk = 0, sys_rst = 1, op_valid = 0, dest_sel = 0;
  logic       wb_en, carry_flag, digit_carry_flag, zero_flag;
  logic [3:0] op = 4'h0;
  logic [6:0] reg_addr = 7'h05, wb_addr;
  logic [7:0] reg_val = 8'h00, literal = 8'h00, acc_out, wb_data;
  int         n_fail = 0, checks_done = 0, cyc = 0;
  bax_top DUT (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .op_valid         (op_valid),
    .op               (op),
    .reg_addr         (reg_addr),
    .dest_sel         (dest_sel),
    .reg_val          (reg_val),
    .literal          (literal),
    .acc_out          (acc_out),
    .wb_data          (wb_data),
    .wb_addr          (wb_addr),
    .wb_en            (wb_en),
    .carry_flag       (carry_flag),
    .digit_carry_flag (digit_carry_flag),
    .zero_flag        (zero_flag)
  );
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 200) begin
      n_fail++;
      conclude();
    end
  end
  task automatic run(logic [3:0] o, logic d, logic [7:0] v, ea, ew, logic [3:0] ef);
    logic [19:0] got;
    @(posedge clk);
    {op_valid, op, dest_sel, reg_val, literal} <= {1'h1, o, d, v, v};
    @(posedge clk);
    op_valid <= 1'h0;
    #1 got = {acc_out, wb_data, wb_en, carry_flag, digit_carry_flag, zero_flag};
    checks_done++;
    if (got !== {ea, ew, ef}) begin
      $display("BAD outputs exp %h got %h", {ea, ew, ef}, got);
      n_fail++;
    end
  endtask : run
  task automatic t_sub();
    run(4'h2, 1'h1, 8'h03, 8'h03, 8'h00, 4'h0);
    run(4'h1, 1'h1, 8'h05, 8'h03, 8'h02, 4'hE);
    run(4'h1, 1'h0, 8'h02, 8'hFF, 8'h02, 4'h0);
    run(4'h1, 1'h0, 8'hFF, 8'h00, 8'h02, 4'h7);
  endtask : t_sub
  task automatic t_swp();
    run(4'h2, 1'h0, 8'hA5, 8'hA5, 8'h02, 4'h6);
    run(4'h4, 1'h1, 8'h3C, 8'hA5, 8'hC3, 4'hE);
    run(4'h4, 1'h0, 8'h00, 8'h00, 8'hC3, 4'h6);
  endtask : t_swp
  task automatic t_xr();
    run(4'h8, 1'h1, 8'h00, 8'h00, 8'h00, 4'hF);
    run(4'h8, 1'h0, 8'h3C, 8'h3C, 8'h00, 4'h6);
  endtask : t_xr
  task automatic t_wba();
    checks_done++;
    if (wb_addr !== 7'h05) begin
      $display("BAD wb_addr exp %h got %h", 7'h05, wb_addr);
      n_fail++;
    end
    @(posedge clk);
    reg_addr <= 7'h7F;
    run(4'h4, 1'h1, 8'h12, 8'h3C, 8'h21, 4'hE);
    checks_done++;
    if (wb_addr !== 7'h7F) begin
      $display("BAD wb_addr exp %h got %h", 7'h7F, wb_addr);
      n_fail++;
    end
  endtask : t_wba
  task automatic t_idle();
    logic [19:0] got;
    @(posedge clk);
    {op, dest_sel, reg_val} <= {4'h1, 1'h0, 8'h3C};
    repeat (2) @(posedge clk);
    #1 got = {acc_out, wb_data, wb_en, carry_flag, digit_carry_flag, zero_flag};
    checks_done++;
    if (got !== {8'h3C, 8'h21, 4'h6}) begin
      $display("BAD idle exp %h got %h", {8'h3C, 8'h21, 4'h6}, got);
      n_fail++;
    end
  endtask : t_idle
  task automatic t_bad();
    run(4'h3, 1'h0, 8'h55, 8'h00, 8'h21, 4'h6);
  endtask : t_bad
  task automatic t_rst();
    logic [26:0] got;
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    #1 got = {acc_out, wb_data, wb_addr, wb_en, carry_flag, digit_carry_flag, zero_flag};
    checks_done++;
    if (got !== 27'h0000000) begin
      $display("BAD reset exp %h got %h", 27'h0000000, got);
      n_fail++;
    end
    run(4'h8, 1'h0, 8'h81, 8'h81, 8'h00, 4'h0);
  endtask : t_rst
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    t_sub();
    t_swp();
    t_xr();
    t_wba();
    t_idle();
    t_bad();
    t_rst();
    conclude();
  end
endmodule : byte_alu_sub_xor_swap_tb
`default_nettype wire
